// >>> ddlw_core.sv
// DLL state, clock-stop tracking and write leveling feedback of the device
`timescale 1ns/1ns
module ddlw_core
  import ddlw_pkg::*;
#(
  parameter int unsigned DLLK_CYCLES = DLLK_CYC
)(
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               upper_lane_strobe,
  input  wire logic               lower_lane_strobe,
  input  wire logic               ck_level,
  input  wire logic               cke,
  input  wire logic               odt,
  input  wire ddlw_cmd_t          cmd,
  input  wire ddlw_mrs_t          mrs,
  input  wire logic               all_bits_fb,
  output      logic [DQ_BITS-1:0] dq_out,
  output      logic [DQ_BITS-1:0] dq_oe,
  output      logic               term_strobe_on,
  output      logic               term_data_on,
  output      ddlw_status_t       status
);
  localparam logic [CNT_BITS-1:0] CKSRE_LOAD = CNT_BITS'(CKSRE_CYC);
  localparam logic [CNT_BITS-1:0] DLLK_LOAD  = CNT_BITS'(DLLK_CYCLES);

  typedef struct packed {
    ddlw_mode_t          mode;
    logic [CNT_BITS-1:0] stop_cnt;
    logic                clk_ign;
    logic                dll_en;
    logic                dll_locked;
    logic [CNT_BITS-1:0] lock_cnt;
    logic                wl;
    logic                qoff;
    logic [2:0]          rtt_nom;
    logic [LANES-1:0]    tog_s1;
    logic [LANES-1:0]    tog_s2;
    logic [LANES-1:0]    tog_s3;
    logic [LANES-1:0]    fb;
    logic                fb_valid;
    logic [DQ_BITS-1:0]  dq_out;
    logic [DQ_BITS-1:0]  dq_oe;
    logic                term_strobe;
    logic                term_data;
  } ddlw_core_t;

  ddlw_core_t          s_reg;
  ddlw_core_t          s_next;
  ddlw_lane_t [LANES-1:0] lane;
  logic [LANES-1:0]    lane_clk;

  assign lane_clk[LANE_UP]  = upper_lane_strobe;
  assign lane_clk[LANE_LOW] = lower_lane_strobe;

  // One sampler per byte lane, each on its own strobe
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    ddlw_lane_sampler u_lane (
      .strobe   (lane_clk[g]),
      .lane_rst (reset),
      .ck_level (ck_level),
      .lane_out (lane[g])
    );
  end

  always_comb begin
    logic [LANES-1:0] ev;
    logic             mr0_wr;
    logic             mr1_wr;
    logic [DQ_BITS-1:0] lane_dq;
    s_next  = s_reg;
    ev      = '0;
    lane_dq = DQ_ZERO;
    mr0_wr  = mrs.we && (mrs.sel == MR0_SEL);
    mr1_wr  = mrs.we && (mrs.sel == MR1_SEL);

    // Power state tracking; clock-stop delay counts from entry
    case (s_reg.mode)
      DDLW_ACTIVE: begin
        if (cmd.sref_entry) begin
          s_next.mode     = DDLW_SELF_REFRESH;
          s_next.stop_cnt = CKSRE_LOAD;
        end else if (!cke) begin
          s_next.mode     = DDLW_POWER_DOWN;
          s_next.stop_cnt = CKSRE_LOAD;
        end
      end
      DDLW_SELF_REFRESH: begin
        if (cmd.sref_exit) begin
          s_next.mode    = DDLW_ACTIVE;
          s_next.clk_ign = 1'b0;
        end
      end
      DDLW_POWER_DOWN: begin
        if (cke) begin
          s_next.mode    = DDLW_ACTIVE;
          s_next.clk_ign = 1'b0;
        end
      end
      default: begin
        s_next.mode = DDLW_ACTIVE;
      end
    endcase

    if (s_reg.mode != DDLW_ACTIVE && s_next.mode != DDLW_ACTIVE) begin
      if (s_reg.stop_cnt > CNT_BITS'(1)) begin
        s_next.stop_cnt = s_reg.stop_cnt - CNT_BITS'(1);
      end else begin
        s_next.clk_ign  = 1'b1;
      end
    end

    // Clock may have changed while ignored, so the lock is no longer
    // trusted until a fresh DLL reset has run its full lock time
    if (s_reg.clk_ign) begin
      s_next.dll_locked = 1'b0;
      s_next.lock_cnt   = '0;
    end

    // Mode register writes
    if (mr1_wr) begin
      s_next.dll_en  = ~mrs.addr[MR1_DLL_OFF];
      s_next.wl      = mrs.addr[MR1_WL_EN];
      s_next.qoff    = mrs.addr[MR1_QOFF];
      s_next.rtt_nom = {mrs.addr[MR1_RTT_B2], mrs.addr[MR1_RTT_B1],
                        mrs.addr[MR1_RTT_B0]};
      if (mrs.addr[MR1_DLL_OFF]) begin
        s_next.dll_locked = 1'b0;
        s_next.lock_cnt   = '0;
      end
    end
    if (mr0_wr && mrs.addr[MR0_DLL_RST] && s_reg.dll_en) begin
      s_next.dll_locked = 1'b0;
      s_next.lock_cnt   = DLLK_LOAD;
    end else if (s_reg.lock_cnt != '0 && !s_reg.clk_ign) begin
      s_next.lock_cnt = s_reg.lock_cnt - CNT_BITS'(1);
      if (s_reg.lock_cnt == CNT_BITS'(1)) begin
        s_next.dll_locked = 1'b1;
      end
    end

    // Toggle crossing from each strobe domain
    s_next.tog_s1 = {lane[LANE_UP].tog, lane[LANE_LOW].tog};
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_s3 = s_reg.tog_s2;
    ev            = s_reg.tog_s2 ^ s_reg.tog_s3;
    for (int i = 0; i < LANES; i++) begin
      if (ev[i] && s_reg.wl) begin
        s_next.fb[i]    = lane[i].sample;
        s_next.fb_valid = 1'b1;
      end
    end
    if (!s_reg.wl) begin
      s_next.fb_valid = 1'b0;
      s_next.fb       = '0;
    end

    // Feedback bus: each lane reports its own strobe
    for (int i = 0; i < LANES; i++) begin
      if (all_bits_fb) begin
        lane_dq[i*LANE_BITS +: LANE_BITS] = {LANE_BITS{s_reg.fb[i]}};
      end else begin
        lane_dq[i*LANE_BITS] = s_reg.fb[i];
      end
    end
    s_next.dq_out = lane_dq;
    // Undriven until the first sample of either lane; a lane not yet sampled then drives 0
    if (s_reg.wl && s_reg.fb_valid && !s_reg.qoff) begin
      s_next.dq_oe = {DQ_BITS{1'b1}};
    end else begin
      s_next.dq_oe = DQ_ZERO;
    end

    // Termination: leveling keeps data pins unterminated
    s_next.term_strobe = odt && (s_reg.rtt_nom != RTT_OFF);
    s_next.term_data   = odt && (s_reg.rtt_nom != RTT_OFF)
                         && !s_reg.wl;
    if (s_reg.mode != DDLW_ACTIVE && !odt) begin
      s_next.term_data   = 1'b0;
      s_next.term_strobe = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg            <= '0;
      s_reg.mode       <= DDLW_ACTIVE;
      s_reg.dll_en     <= 1'b1;
      s_reg.dll_locked <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dq_out               = s_reg.dq_out;
  assign dq_oe                = s_reg.dq_oe;
  assign term_strobe_on       = s_reg.term_strobe;
  assign term_data_on         = s_reg.term_data;
  assign status.dll_enabled   = s_reg.dll_en;
  assign status.dll_locked    = s_reg.dll_locked;
  assign status.clock_ignored = s_reg.clk_ign;
  assign status.wl_active     = s_reg.wl;
  assign status.out_buf_off   = s_reg.qoff;
endmodule

// >>> ddlw_core_sva.sv
// Checker bound to the leveling core
`timescale 1ns/1ns
module ddlw_core_sva
  import ddlw_pkg::*;
#(
  parameter int unsigned DLLK_CYCLES = DLLK_CYC
)(
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         odt,
  input wire ddlw_cmd_t    cmd,
  input wire ddlw_mrs_t    mrs,
  input wire logic         all_bits_fb,
  input wire logic [15:0]  dq_out,
  input wire logic [15:0]  dq_oe,
  input wire logic         term_strobe_on,
  input wire logic         term_data_on,
  input wire ddlw_status_t status
);
  logic [CNT_BITS-1:0] low_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Restarts on every MR0 write, so a lost lock is timed from the reset
  always_ff @(posedge mclk)
    if (reset || status.dll_locked || (mrs.we && mrs.sel == MR0_SEL))
      low_cnt <= '0;
    else
      low_cnt <= low_cnt + 1'b1;
  chk_mr1_bits: assert property (
    mrs.we && mrs.sel == MR1_SEL |=>
    status.wl_active == $past(mrs.addr[MR1_WL_EN]) &&
    status.out_buf_off == $past(mrs.addr[MR1_QOFF]))
    else $error("MR1 leveling bits not taken");
  chk_dll_enable: assert property (
    mrs.we && mrs.sel == MR1_SEL |=>
    status.dll_enabled != $past(mrs.addr[MR1_DLL_OFF]))
    else $error("DLL enable bit not taken");
  chk_dll_reset: assert property (
    mrs.we && mrs.sel == MR0_SEL && mrs.addr[MR0_DLL_RST] &&
    status.dll_enabled |=> !status.dll_locked)
    else $error("DLL reset not started");
  chk_lock_time: assert property (
    $rose(status.dll_locked) |-> low_cnt == DLLK_CYCLES)
    else $error("DLL lock time wrong");
  chk_clk_ignore: assert property (
    cmd.sref_entry |-> ##2 status.clock_ignored)
    else $error("clock not ignored in self refresh");
  chk_term_odt: assert property (
    !$past(odt) |-> !term_strobe_on && !term_data_on)
    else $error("termination on with ODT low");
  chk_wl_data_term: assert property (
    status.wl_active && $past(status.wl_active) |-> !term_data_on)
    else $error("data termination on in leveling");
  chk_oe_idle: assert property (
    (!status.wl_active && !$past(status.wl_active)) ||
    (status.out_buf_off && $past(status.out_buf_off)) |->
    dq_oe == DQ_ZERO)
    else $error("data driven outside leveling");
  chk_prime_bits: assert property (
    !all_bits_fb && !$past(all_bits_fb) |->
    (dq_out & 16'hFEFE) == DQ_ZERO)
    else $error("non-prime bits not low");
  cov_sref: cover property (cmd.sref_entry);
  cov_relock: cover property ($rose(status.dll_locked));
  cov_fb: cover property (dq_oe != DQ_ZERO);
endmodule
bind ddlw_core ddlw_core_sva #(.DLLK_CYCLES(DLLK_CYCLES)) u_sva (
  .mclk           (mclk),
  .reset          (reset),
  .odt            (odt),
  .cmd            (cmd),
  .mrs            (mrs),
  .all_bits_fb    (all_bits_fb),
  .dq_out         (dq_out),
  .dq_oe          (dq_oe),
  .term_strobe_on (term_strobe_on),
  .term_data_on   (term_data_on),
  .status         (status)
);

// >>> ddlw_core_tb.sv
// Self-checking bench for the DLL switch and leveling core
`timescale 1ns/1ns
module ddlw_core_tb import ddlw_pkg::*; ;
  logic         mclk, reset, ck_level, cke, odt, all_bits_fb;
  logic         up_stb, lo_stb, term_strobe_on, term_data_on;
  logic [15:0]  dq_out, dq_oe;
  logic [1:0]   term_pair;
  assign term_pair = {term_strobe_on, term_data_on};
  ddlw_cmd_t    cmd;
  ddlw_mrs_t    mrs;
  ddlw_status_t status;
  int           num_errors, n_checks;
  ddlw_core #(.DLLK_CYCLES(8)) u_ddlw_core (
    .mclk(mclk), .reset(reset), .upper_lane_strobe(up_stb),
    .lower_lane_strobe(lo_stb), .ck_level(ck_level), .cke(cke),
    .odt(odt), .cmd(cmd), .mrs(mrs), .all_bits_fb(all_bits_fb),
    .dq_out(dq_out), .dq_oe(dq_oe), .term_strobe_on(term_strobe_on),
    .term_data_on(term_data_on), .status(status));
  ddlw_ctl_model u_ddlw_ctl_model (
    .upper_lane_strobe(up_stb), .lower_lane_strobe(lo_stb));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic mr_wr(logic [1:0] s, logic [15:0] a);
    mrs = '{1'b1, s, a};
    tick(1);
    mrs.we = 1'b0;
    tick(2);
  endtask
  // Feedback settles on the fourth mclk edge after the strobe edge, so wait eight
  task automatic fb(bit up, logic ck);
    ck_level = ck;
    tick(1);
    u_ddlw_ctl_model.pulse(up);
    tick(8);
  endtask
  function automatic logic [15:0] st();
    return {11'h000, status};
  endfunction
  // Latencies reprogrammed after this in a real flow
  task automatic relock();
    mr_wr(MR0_SEL, 16'h0100);
    chk("lock_lo", st(), 16'h0010);
    tick(4);
    chk("lock_wait", st(), 16'h0010);
    tick(2);
    chk("lock_hi", st(), 16'h0018);
  endtask
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    cke = 1'b1;
    odt = 1'b0;
    ck_level = 1'b0;
    all_bits_fb = 1'b0;
    cmd = '0;
    mrs = '0;
    num_errors = 0;
    n_checks = 0;
    tick(12);
    reset = 1'b0;
    tick(1);
    chk("reset", st(), 16'h0018);
    mr_wr(MR1_SEL, 16'h0001);
    chk("dll_off", st(), 16'h0000);
    cmd.sref_entry = 1'b1;
    tick(1);
    cmd.sref_entry = 1'b0;
    tick(2);
    chk("sref_ign", st(), 16'h0004);
    // Clock kept at one rate, changes only allowed here
    cmd.sref_exit = 1'b1;
    tick(1);
    cmd.sref_exit = 1'b0;
    tick(3);
    chk("sref_exit", st(), 16'h0000);
    mr_wr(MR0_SEL, 16'h0100);
    chk("rst_refused", st(), 16'h0000);
    mr_wr(MR1_SEL, 16'h0000);
    chk("dll_on", st(), 16'h0010);
    relock();
    cke = 1'b0;
    tick(3);
    chk("pd_ign", {15'h0000, status.clock_ignored}, 16'h0001);
    cke = 1'b1;
    tick(4);
    chk("pd_exit", st(), 16'h0010);
    relock();
    mr_wr(MR1_SEL, 16'h0084);
    chk("wl_on", st(), 16'h001A);
    chk("oe_idle", dq_oe, DQ_ZERO);
    odt = 1'b1;
    tick(2);
    chk("wl_term", {14'h0000, term_pair}, 16'h0002);
    fb(1'b0, 1'b1);
    chk("lo_fb", {dq_oe[7:0], dq_out[7:0]}, 16'hFF01);
    fb(1'b1, 1'b0);
    chk("up_fb0", dq_out, 16'h0001);
    fb(1'b1, 1'b1);
    chk("up_fb1", dq_out, 16'h0101);
    chk("up_oe", dq_oe, 16'hFFFF);
    all_bits_fb = 1'b1;
    fb(1'b0, 1'b1);
    chk("all_fb", dq_out, 16'hFFFF);
    mr_wr(MR1_SEL, 16'h1084);
    chk("qoff_st", st(), 16'h001B);
    chk("qoff_oe", dq_oe, DQ_ZERO);
    mr_wr(MR1_SEL, 16'h0004);
    tick(1);
    chk("wl_exit", {dq_oe[13:0], term_pair}, 16'h0003);
    odt = 1'b0;
    tick(2);
    chk("odt_low", {14'h0000, term_pair}, 16'h0000);
    // Termination disabled in MR1 keeps both off whatever ODT does
    odt = 1'b1;
    mr_wr(MR1_SEL, 16'h0000);
    chk("rtt_off", {14'h0000, term_pair}, 16'h0000);
    odt = 1'b0;
    tick(2);
    end_of_test();
  end
endmodule

// >>> ddlw_ctl_model.sv
// Controller-side strobe source for write leveling
`timescale 1ns/1ns
module ddlw_ctl_model (
  output logic upper_lane_strobe,
  output logic lower_lane_strobe
);
  logic lclk;
  // Strobes rest low between pulses, link clock runs apart from mclk
  initial begin
    upper_lane_strobe = 1'b0;
    lower_lane_strobe = 1'b0;
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end
  // One rising edge per call, delay steps left to the caller
  task automatic pulse(bit up);
    @(posedge lclk);
    if (up) upper_lane_strobe = 1'b1;
    else lower_lane_strobe = 1'b1;
    @(negedge lclk);
    upper_lane_strobe = 1'b0;
    lower_lane_strobe = 1'b0;
  endtask
endmodule

// >>> ddlw_lane_sampler.sv
// Per-lane strobe-domain capture of the clock level
`timescale 1ns/1ns
module ddlw_lane_sampler
  import ddlw_pkg::*;
(
  input  wire logic       strobe,
  input  wire logic       lane_rst,
  input  wire logic       ck_level,
  output      ddlw_lane_t lane_out
);
  ddlw_lane_t state_reg;
  ddlw_lane_t state_next;

  // Capture flop is the sampling point itself; metastability is intrinsic
  always_comb begin
    state_next        = state_reg;
    state_next.sample = ck_level;
    state_next.tog    = ~state_reg.tog;
  end

  // Strobe stands still outside leveling, so reset cannot wait for an edge
  always_ff @(posedge strobe or posedge lane_rst) begin
    if (lane_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lane_out = state_reg;
endmodule

// >>> ddlw_pkg.sv
// Shared constants and carrier types for the DLL switch and leveling block
package ddlw_pkg;
  localparam int unsigned MR_BITS      = 16;
  localparam logic [1:0]  MR0_SEL      = 2'h0;
  localparam logic [1:0]  MR1_SEL      = 2'h1;
  localparam int unsigned MR0_DLL_RST  = 8;
  localparam int unsigned MR1_DLL_OFF  = 0;
  localparam int unsigned MR1_RTT_B0   = 2;
  localparam int unsigned MR1_RTT_B1   = 6;
  localparam int unsigned MR1_WL_EN    = 7;
  localparam int unsigned MR1_RTT_B2   = 9;
  localparam int unsigned MR1_QOFF     = 12;
  localparam int unsigned DQ_BITS      = 16;
  localparam int unsigned LANE_BITS    = 8;
  localparam int unsigned LANES        = 2;
  localparam int unsigned LANE_LOW     = 0;
  localparam int unsigned LANE_UP      = 1;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CKSRE_NS     = 10;
  localparam int unsigned CKSRE_RAW    =
    (CKSRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CKSRE_CYC    = (CKSRE_RAW < 1) ? 1 : CKSRE_RAW;
  localparam int unsigned DLLK_CYC     = 512;
  localparam int unsigned CNT_BITS     = 10;
  localparam logic [2:0]  RTT_OFF      = 3'h0;
  localparam logic [15:0] DQ_ZERO      = 16'h0000;

  typedef enum logic [1:0] {
    DDLW_ACTIVE,
    DDLW_SELF_REFRESH,
    DDLW_POWER_DOWN
  } ddlw_mode_t;

  typedef struct packed {
    logic                  we;
    logic [1:0]            sel;
    logic [MR_BITS-1:0]    addr;
  } ddlw_mrs_t;

  typedef struct packed {
    logic sref_entry;
    logic sref_exit;
  } ddlw_cmd_t;

  typedef struct packed {
    logic sample;
    logic tog;
  } ddlw_lane_t;

  typedef struct packed {
    logic dll_enabled;
    logic dll_locked;
    logic clock_ignored;
    logic wl_active;
    logic out_buf_off;
  } ddlw_status_t;
endpackage
